// ### core/cisd_cfg.svh
`ifndef CISD_CFG_SVH
`define CISD_CFG_SVH

// Reset values of the parameter and fixed record bytes.
`define CISD_FN_RST 8'h30
`define CISD_MODINFO_RST 8'h15
`define CISD_CHANNEL_KIND_RST 8'h71
`define CISD_DIAG_BITS_PER_CHANNEL_RST 8'h08
`define CISD_CHANNEL_COUNT_RST 8'h02

// Record set selectors and the length of each view in bytes.
`define CISD_SET_SHORT 8'h00
`define CISD_SET_FULL 8'h01
`define CISD_LEN_SHORT 5'd4
`define CISD_LEN_FULL 5'd20

// Byte offsets inside the diagnostic record.
`define CISD_OFS_MODFLAGS 5'd0
`define CISD_OFS_MODINFO 5'd1
`define CISD_OFS_RSVD_C 5'd2
`define CISD_OFS_INTFLAGS 5'd3
`define CISD_OFS_CHKIND 5'd4
`define CISD_OFS_DIAG_BITS_PER_CHANNEL 5'd5
`define CISD_OFS_CHANNEL_COUNT 5'd6
`define CISD_OFS_GRPERR 5'd7
`define CISD_OFS_CHAN0_ERROR_FLAGS 5'd8
`define CISD_OFS_US 5'd16

// Bit positions in the module and internal flag bytes.
`define CISD_BIT_MODFAIL 0
`define CISD_BIT_INTERR 1
`define CISD_BIT_EXTERR 2
`define CISD_BIT_CHANNEL_GROUP_ERRORS 3
`define CISD_BIT_AUX 4
`define CISD_BIT_PARAM 7
`define CISD_BIT_BUFOVF 3
`define CISD_BIT_COMM 4

// Scaled limits of both formats.
`define CISD_OVER_A 32511
`define CISD_UNDER_A -4864
`define CISD_OVER_B 20480
`define CISD_UNDER_B -3277

// Converter counts: 160 per mA, so 4 mA is 640 and 20 mA is 3200.
`define CISD_RAW_4MA 13'sd640
`define CISD_K_A20 (27648 * 65536 / 3200)
`define CISD_K_A16 (27648 * 65536 / 2560)
`define CISD_K_B20 (16384 * 65536 / 3200)
`define CISD_K_B16 (16384 * 65536 / 2560)
`define CISD_ROUND 40'sd32768

// Microsecond ticker timing at a 20 ns clock.
`define CISD_US_NS 1000
`define CISD_CLK_NS 20
`define CISD_US_CYC (`CISD_US_NS / `CISD_CLK_NS)

`endif

// ### core/cisd_pkg.sv
`default_nettype none
package cisd_pkg;

    // Channel function codes; any other byte is a parameter error.
    typedef enum logic [7:0] {
        CISD_FN_A4 = 8'h30,
        CISD_FN_A0 = 8'h31,
        CISD_FN_B4 = 8'h40,
        CISD_FN_B0 = 8'h41,
        CISD_FN_OFF = 8'hff
    } cisd_fn_e;

    // One channel-specific error byte, most significant bit first.
    typedef struct packed {
        logic ovf;
        logic unf;
        logic [4:0] rsvd;
        logic cfg;
    } cisd_chan_err_s;

    // A read request for one byte of the diagnostic record.
    typedef struct packed {
        logic [7:0] set;
        logic [4:0] idx;
    } cisd_rec_req_s;

    typedef logic [1:0][15:0] cisd_values_t;

endpackage
`default_nettype wire

// ### core/cisd_top.sv
// Function
// - Code FFh switches the channel off: no measurement, no scaling.
// - Code 31h: 0 mA gives 0, 20 mA 27648; limits 32511 and -4864.
// - Code 41h: 0 mA gives 0, 20 mA 16384; limits 20480 and -3277.
// - Code 30h: 4 mA gives 0, 20 mA 27648; limits 32511 and -4864.
// - Code 40h: 4 mA gives 0, 20 mA 16384; limits 20480 and -3277.
// - Errors light the channel indicator and enter the record; no interrupt.
// - Set 01h reads the whole record, set 00h its first four bytes.
// - Byte 0: failure, internal, external, channel, supply, parameter bits.
// - Module information byte reads 15h: analog class, channel info present.
// - Fourth byte flags diagnostic buffer overflow and communication error.
// - Channel kind byte reads 71h, analog input.
// - Record holds 08h bits, 02h channels, error bytes, reserved, ticker.
// - Microsecond ticker starts at zero, wraps, snapshot taken on events.
// - Group error byte: bit 0 for channel 0, bit 1 for channel 1.
// - Channel error byte: bit 0 parameter, bit 6 underflow, bit 7 overflow.
// - Each function code is one byte with reset value 30h.
`include "cisd_cfg.svh"
`default_nettype none
module cisd_top (
    input wire logic clock,
    input wire logic srst,
    input wire logic ce,
    input wire logic fn_we,
    input wire logic fn_idx,
    input wire logic [7:0] fn_data,
    input wire logic adc_valid,
    input wire logic adc_chan,
    input wire logic [11:0] adc_code,
    input wire logic module_fail,
    input wire logic internal_err,
    input wire logic aux_supply_missing,
    input wire logic diag_buf_ovf,
    input wire logic comm_err,
    input wire logic rd_req,
    input wire cisd_pkg::cisd_rec_req_s rd_sel,
    output logic rd_valid,
    output logic rd_err,
    output logic [7:0] rd_data,
    output cisd_pkg::cisd_values_t chan_value,
    output logic [1:0] chan_led,
    output logic module_led
);

    // True for the four measuring codes and the off code.
    function automatic logic fn_known(input logic [7:0] fn);
        fn_known = (fn == cisd_pkg::CISD_FN_A4) || (fn == cisd_pkg::CISD_FN_A0)
            || (fn == cisd_pkg::CISD_FN_B4) || (fn == cisd_pkg::CISD_FN_B0)
            || (fn == cisd_pkg::CISD_FN_OFF);
    endfunction

    logic [1:0][7:0] fn_q;
    logic [1:0][7:0] fn_d;
    cisd_pkg::cisd_chan_err_s [1:0] err_q;
    cisd_pkg::cisd_chan_err_s [1:0] err_d;
    logic [1:0][15:0] val_q;
    logic [1:0][15:0] val_d;
    logic [1:0] led_q;
    logic [1:0] led_d;
    logic [7:0] modflags_q;
    logic [7:0] modflags_d;
    logic [7:0] intflags_q;
    logic [7:0] intflags_d;
    logic modled_q;
    logic modled_d;
    logic [5:0] pre_q;
    logic [5:0] pre_d;
    logic [31:0] us_q;
    logic [31:0] us_d;
    logic [31:0] snap_q;
    logic [31:0] snap_d;
    logic rdv_q;
    logic rdv_d;
    logic rde_q;
    logic rde_d;
    logic [7:0] rdd_q;
    logic [7:0] rdd_d;
    logic [19:0][7:0] rec;
    logic new_event;

    // Function code bytes, written by the controller one at a time.
    always_comb
    begin
        fn_d = fn_q;
        if (fn_we)
        begin
            fn_d[fn_idx] = fn_data;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            fn_q <= {2{`CISD_FN_RST}};
        end
        else if (ce)
        begin
            fn_q <= fn_d;
        end
    end

    // Per-channel scaling. Scale factors are Q16 so a single multiply
    // replaces a divider; rounding keeps the nominal end points exact.
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_chan
            logic signed [12:0] diff;
            logic signed [39:0] prod;
            logic signed [39:0] scaled;
            logic signed [39:0] k;
            logic signed [39:0] over;
            logic signed [39:0] under;

            always_comb
            begin
                diff = $signed({1'b0, adc_code});
                k = 40'sd0;
                over = 40'sd0;
                under = 40'sd0;
                unique case (fn_q[gi])
                    cisd_pkg::CISD_FN_A0:
                    begin
                        k = 40'(`CISD_K_A20);
                        over = 40'(`CISD_OVER_A);
                        under = 40'(`CISD_UNDER_A);
                    end
                    cisd_pkg::CISD_FN_B0:
                    begin
                        k = 40'(`CISD_K_B20);
                        over = 40'(`CISD_OVER_B);
                        under = 40'(`CISD_UNDER_B);
                    end
                    cisd_pkg::CISD_FN_A4:
                    begin
                        diff = diff - `CISD_RAW_4MA;
                        k = 40'(`CISD_K_A16);
                        over = 40'(`CISD_OVER_A);
                        under = 40'(`CISD_UNDER_A);
                    end
                    cisd_pkg::CISD_FN_B4:
                    begin
                        diff = diff - `CISD_RAW_4MA;
                        k = 40'(`CISD_K_B16);
                        over = 40'(`CISD_OVER_B);
                        under = 40'(`CISD_UNDER_B);
                    end
                    default:
                    begin
                        k = 40'sd0;
                    end
                endcase
                prod = 40'(diff) * k;
                scaled = (prod + `CISD_ROUND) >>> 16;
                val_d[gi] = val_q[gi];
                err_d[gi] = err_q[gi];
                err_d[gi].rsvd = 5'h00;
                err_d[gi].cfg = !fn_known(fn_q[gi]);
                if (fn_q[gi] == cisd_pkg::CISD_FN_OFF || !fn_known(fn_q[gi]))
                begin
                    val_d[gi] = 16'h0000;
                    err_d[gi].ovf = 1'b0;
                    err_d[gi].unf = 1'b0;
                end
                else if (adc_valid && adc_chan == 1'(gi))
                begin
                    err_d[gi].ovf = scaled > over;
                    err_d[gi].unf = scaled < under;
                    if (scaled > over)
                    begin
                        val_d[gi] = over[15:0];
                    end
                    else if (scaled < under)
                    begin
                        val_d[gi] = under[15:0];
                    end
                    else
                    begin
                        val_d[gi] = scaled[15:0];
                    end
                end
                led_d[gi] = |err_d[gi];
            end
        end
    endgenerate

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            val_q <= '0;
            err_q <= '0;
            led_q <= 2'h0;
        end
        else if (ce)
        begin
            val_q <= val_d;
            err_q <= err_d;
            led_q <= led_d;
        end
    end

    // Module-level flags follow their causes; there is no interrupt path.
    always_comb
    begin
        modflags_d = 8'h00;
        modflags_d[`CISD_BIT_MODFAIL] = module_fail;
        modflags_d[`CISD_BIT_INTERR] = internal_err | diag_buf_ovf | comm_err;
        modflags_d[`CISD_BIT_EXTERR] = err_d[0].ovf | err_d[0].unf
            | err_d[1].ovf | err_d[1].unf;
        modflags_d[`CISD_BIT_CHANNEL_GROUP_ERRORS] = led_d[0] | led_d[1];
        modflags_d[`CISD_BIT_AUX] = aux_supply_missing;
        modflags_d[`CISD_BIT_PARAM] = err_d[0].cfg | err_d[1].cfg;
        intflags_d = 8'h00;
        intflags_d[`CISD_BIT_BUFOVF] = diag_buf_ovf;
        intflags_d[`CISD_BIT_COMM] = comm_err;
        modled_d = |modflags_d;
        new_event = |((modflags_d & ~modflags_q)
            | (intflags_d & ~intflags_q));
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            modflags_q <= 8'h00;
            intflags_q <= 8'h00;
            modled_q <= 1'b0;
        end
        else if (ce)
        begin
            modflags_q <= modflags_d;
            intflags_q <= intflags_d;
            modled_q <= modled_d;
        end
    end

    // Microsecond ticker; the 32-bit count wraps to zero by itself.
    always_comb
    begin
        pre_d = pre_q + 6'd1;
        us_d = us_q;
        if (pre_q == 6'(`CISD_US_CYC - 1))
        begin
            pre_d = 6'd0;
            us_d = us_q + 32'd1;
        end
        snap_d = new_event ? us_q : snap_q;
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            pre_q <= 6'd0;
            us_q <= 32'h0000_0000;
            snap_q <= 32'h0000_0000;
        end
        else if (ce)
        begin
            pre_q <= pre_d;
            us_q <= us_d;
            snap_q <= snap_d;
        end
    end

    // The record is one byte image; both views index the same bytes,
    // so the short view can never disagree with the full one.
    always_comb
    begin
        rec = '0;
        rec[`CISD_OFS_MODFLAGS] = modflags_q;
        rec[`CISD_OFS_MODINFO] = `CISD_MODINFO_RST;
        rec[`CISD_OFS_INTFLAGS] = intflags_q;
        rec[`CISD_OFS_CHKIND] = `CISD_CHANNEL_KIND_RST;
        rec[`CISD_OFS_DIAG_BITS_PER_CHANNEL] = `CISD_DIAG_BITS_PER_CHANNEL_RST;
        rec[`CISD_OFS_CHANNEL_COUNT] = `CISD_CHANNEL_COUNT_RST;
        rec[`CISD_OFS_GRPERR] = {6'h00, led_q};
        rec[`CISD_OFS_CHAN0_ERROR_FLAGS] = err_q[0];
        rec[`CISD_OFS_CHAN0_ERROR_FLAGS + 5'd1] = err_q[1];
        rec[`CISD_OFS_US] = snap_q[7:0];
        rec[`CISD_OFS_US + 5'd1] = snap_q[15:8];
        rec[`CISD_OFS_US + 5'd2] = snap_q[23:16];
        rec[`CISD_OFS_US + 5'd3] = snap_q[31:24];
        rdv_d = rd_req;
        rde_d = 1'b0;
        rdd_d = 8'h00;
        if (rd_req)
        begin
            if ((rd_sel.set == `CISD_SET_SHORT
                    && rd_sel.idx < `CISD_LEN_SHORT)
                || (rd_sel.set == `CISD_SET_FULL
                    && rd_sel.idx < `CISD_LEN_FULL))
            begin
                rdd_d = rec[rd_sel.idx];
            end
            else
            begin
                rde_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            rdv_q <= 1'b0;
            rde_q <= 1'b0;
            rdd_q <= 8'h00;
        end
        else if (ce)
        begin
            rdv_q <= rdv_d;
            rde_q <= rde_d;
            rdd_q <= rdd_d;
        end
    end

    assign rd_valid = rdv_q;
    assign rd_err = rde_q;
    assign rd_data = rdd_q;
    assign chan_value = val_q;
    assign chan_led = led_q;
    assign module_led = modled_q;

    off_quiet_a: assert property (@(posedge clock) disable iff (srst)
        ce && fn_q[0] == cisd_pkg::CISD_FN_OFF && adc_valid && !adc_chan
        |=> chan_value[0] == 16'h0000 && !chan_led[0])
        else $error("switched-off channel produced a value or error");

    scale_a20_a: assert property (@(posedge clock) disable iff (srst)
        ce && fn_q[0] == cisd_pkg::CISD_FN_A0 && adc_valid && !adc_chan
        && adc_code == 12'hc80 |=> chan_value[0] == 16'h6c00)
        else $error("20 mA in format A did not give 27648");

    scale_b20_a: assert property (@(posedge clock) disable iff (srst)
        ce && fn_q[1] == cisd_pkg::CISD_FN_B0 && adc_valid && adc_chan
        && adc_code == 12'hc80 |=> chan_value[1] == 16'h4000)
        else $error("20 mA in format B did not give 16384");

    scale_a4_a: assert property (@(posedge clock) disable iff (srst)
        ce && fn_q[0] == cisd_pkg::CISD_FN_A4 && adc_valid && !adc_chan
        && adc_code == 12'h280 |=> chan_value[0] == 16'h0000 && !chan_led[0])
        else $error("4 mA in live-zero format A did not give zero");

    over_clip_a: assert property (@(posedge clock) disable iff (srst)
        ce && fn_q[0] == cisd_pkg::CISD_FN_B4 && adc_valid && !adc_chan
        && adc_code == 12'hfff
        |=> chan_value[0] == 16'h5000 && chan_led[0] && module_led)
        else $error("overflow not clipped, flagged and shown");

    short_view_a: assert property (@(posedge clock) disable iff (srst)
        ce && rd_req && rd_sel.set == 8'h00 && rd_sel.idx == 5'd4
        |=> rd_valid && rd_err)
        else $error("short view answered beyond its fourth byte");

    mod_info_a: assert property (@(posedge clock) disable iff (srst)
        ce && rd_req && rd_sel.set == 8'h01 && rd_sel.idx == 5'd1
        |=> rd_valid && !rd_err && rd_data == 8'h15)
        else $error("module information byte is not 15h");

    ticker_step_a: assert property (@(posedge clock) disable iff (srst)
        ce && pre_q == 6'd49 |=> us_q == $past(us_q) + 32'd1)
        else $error("ticker did not advance after 50 cycles");

    param_err_a: assert property (@(posedge clock) disable iff (srst)
        ce && !fn_known(fn_q[1]) |=> err_q[1].cfg && rec[0][7])
        else $error("unknown function code not reported");

endmodule
`default_nettype wire

// ### verif/cisd_reader.sv
`default_nettype none
// Behavioural backplane reader that fetches one record byte per call.
module cisd_reader (
    input wire logic clock,
    output var logic rd_req,
    output var cisd_pkg::cisd_rec_req_s rd_sel,
    input wire logic rd_valid,
    input wire logic rd_err,
    input wire logic [7:0] rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle selector is driven inverted so a stale request never matches.
    initial
    begin
        rd_req = 1'b0;
        rd_sel = '1;
    end
    // One-edge request, then a bounded wait for the registered answer.
    task automatic read_byte(input logic [7:0] set, input logic [4:0] idx,
        output logic [7:0] data, output logic err, output logic hung);
        int n;
        @(posedge clock);
        rd_req <= 1'b1;
        rd_sel <= {set, idx};
        @(posedge clock);
        rd_req <= 1'b0;
        rd_sel <= ~{set, idx};
        hung = 1'b1;
        data = 8'h00;
        err = 1'b1;
        for (n = 0; n < 4 && hung; n++)
        begin
            #1;
            if (rd_valid === 1'b1)
            begin
                data = rd_data;
                err = rd_err;
                hung = 1'b0;
            end
            else
                @(posedge clock);
        end
    endtask
endmodule
`default_nettype wire

// ### verif/tb_current_input_scaling_diag.sv
`default_nettype none
module tb_current_input_scaling_diag;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic fn_we = 1'b0;
    logic fn_idx = 1'b0;
    logic [7:0] fn_data = 8'h00;
    logic adc_valid = 1'b0;
    logic adc_chan = 1'b0;
    logic [11:0] adc_code = 12'h000;
    logic [4:0] flg = 5'h00;
    logic rd_req;
    cisd_pkg::cisd_rec_req_s rd_sel;
    logic rd_valid;
    logic rd_err;
    logic [7:0] rd_data;
    cisd_pkg::cisd_values_t chan_value;
    logic [1:0] chan_led;
    logic module_led;
    int err_count = 0;
    int checked = 0;
    int cyc = 0;

    cisd_top uut (.clock(clock), .srst(srst), .ce(ce), .fn_we(fn_we),
        .fn_idx(fn_idx), .fn_data(fn_data), .adc_valid(adc_valid),
        .adc_chan(adc_chan), .adc_code(adc_code), .module_fail(flg[0]),
        .internal_err(flg[1]), .aux_supply_missing(flg[2]),
        .diag_buf_ovf(flg[3]), .comm_err(flg[4]), .rd_req(rd_req),
        .rd_sel(rd_sel), .rd_valid(rd_valid), .rd_err(rd_err),
        .rd_data(rd_data), .chan_value(chan_value), .chan_led(chan_led),
        .module_led(module_led));
    cisd_reader u_rd (.clock(clock), .rd_req(rd_req), .rd_sel(rd_sel),
        .rd_valid(rd_valid), .rd_err(rd_err), .rd_data(rd_data));

    // Free-running clock and a count of clock-enabled cycles since reset release.
    always #10 clock = ~clock;
    always @(posedge clock)
        if (!srst && ce)
            cyc <= cyc + 1;

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Reads one byte and compares data and error; a hang ends the run.
    task automatic rd_chk(input logic [7:0] set, input logic [4:0] idx,
        input logic [7:0] exp_d, input logic exp_e);
        logic [7:0] d;
        logic e;
        logic h;
        u_rd.read_byte(set, idx, d, e, h);
        if (h)
        begin
            err_count++;
            give_verdict();
        end
        else
        begin
            check(d, exp_d);
            check(e, exp_e);
        end
    endtask

    task automatic wr_fn(input logic ch, input logic [7:0] code);
        @(posedge clock);
        fn_we <= 1'b1;
        fn_idx <= ch;
        fn_data <= code;
        @(posedge clock);
        fn_we <= 1'b0;
    endtask

    task automatic conv(input logic ch, input logic [11:0] code);
        @(posedge clock);
        adc_valid <= 1'b1;
        adc_chan <= ch;
        adc_code <= code;
        @(posedge clock);
        adc_valid <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
    endtask

    // Whole record after reset, short view, and refused selections.
    task automatic t_reset();
        logic [7:0] exp [20];
        exp = '{8'h00, 8'h15, 8'h00, 8'h00, 8'h71, 8'h08, 8'h02,
            8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 20; i++)
            rd_chk(8'h01, i[4:0], exp[i], 1'b0);
        for (int i = 0; i < 4; i++)
            rd_chk(8'h00, i[4:0], exp[i], 1'b0);
        rd_chk(8'h00, 5'd4, 8'h00, 1'b1);
        rd_chk(8'h01, 5'd20, 8'h00, 1'b1);
        rd_chk(8'h02, 5'd0, 8'h00, 1'b1);
        conv(1'b1, 12'd3200);
        check(chan_value[1], 16'h6c00);
        $display("test reset done");
    endtask

    // Every function code, limits and a bad code, on alternating channels.
    task automatic t_scale();
        logic [7:0] fn [8];
        logic [11:0] ad [8];
        logic [15:0] val [8];
        logic [7:0] eb [8];
        logic ch;
        logic led;
        fn = '{8'h30, 8'h30, 8'h31, 8'h31, 8'h41, 8'h40, 8'hff, 8'h55};
        ad = '{12'd3200, 12'd0, 12'd1600, 12'd4095, 12'd3200, 12'd1920,
            12'd3200, 12'd3200};
        val = '{16'h6c00, 16'hed00, 16'h3600, 16'h7eff, 16'h4000, 16'h2000,
            16'h0000, 16'h0000};
        eb = '{8'h00, 8'h40, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h01};
        for (int i = 0; i < 8; i++)
        begin
            ch = i[0];
            led = (eb[i] != 8'h00);
            wr_fn(ch, fn[i]);
            conv(ch, ad[i]);
            check(chan_value[ch], val[i]);
            check(chan_led[ch], led);
            check(module_led, led);
            rd_chk(8'h01, 5'd8 + 5'(ch), eb[i], 1'b0);
            rd_chk(8'h01, 5'd0, {eb[i][0], 3'h0, led, |eb[i][7:6], 2'h0},
                1'b0);
            rd_chk(8'h01, 5'd7, {6'h00, ch & led, ~ch & led},
                1'b0);
            wr_fn(ch, 8'h30);
            conv(ch, 12'd640);
        end
        $display("test scale done");
    endtask

    // Each device flag alone, then the event snapshot of the ticker.
    task automatic t_flags();
        logic [7:0] b0 [5];
        logic [7:0] b3 [5];
        logic [31:0] snap;
        logic [7:0] b;
        logic e;
        logic h;
        int at;
        b0 = '{8'h01, 8'h02, 8'h10, 8'h02, 8'h02};
        b3 = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h10};
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clock);
            flg <= 5'h01 << i;
            rd_chk(8'h00, 5'd0, b0[i], 1'b0);
            rd_chk(8'h00, 5'd3, b3[i], 1'b0);
            check(module_led, 1'b1);
            @(posedge clock);
            flg <= 5'h00;
        end
        repeat (300) @(posedge clock);
        flg <= 5'h01;
        at = cyc / 50;
        for (int i = 0; i < 4; i++)
        begin
            u_rd.read_byte(8'h01, 5'd16 + 5'(i), b, e, h);
            if (h)
            begin
                err_count++;
                give_verdict();
            end
            else
            begin
                snap[8*i+:8] = b;
                check(e, 1'b0);
            end
        end
        check(snap >= at - 1 && snap <= at + 1, 1'b1);
        @(posedge clock);
        flg <= 5'h00;
        $display("test flags done");
    endtask

    // End points and clipping that the alternating sweep never reaches.
    task automatic t_limits();
        wr_fn(1'b0, 8'h31);
        conv(1'b0, 12'd3200);
        check(chan_value[0], 16'h6c00);
        wr_fn(1'b1, 8'h41);
        conv(1'b1, 12'd3200);
        check(chan_value[1], 16'h4000);
        wr_fn(1'b0, 8'h40);
        conv(1'b0, 12'd4095);
        check(chan_value[0], 16'h5000);
        check(chan_led[0], 1'b1);
        rd_chk(8'h01, 5'd8, 8'h80, 1'b0);
        conv(1'b0, 12'd0);
        check(chan_value[0], 16'hf333);
        rd_chk(8'h01, 5'd8, 8'h40, 1'b0);
        wr_fn(1'b0, 8'h30);
        conv(1'b0, 12'd640);
        check(chan_led[0], 1'b0);
        wr_fn(1'b1, 8'h30);
        $display("test limits done");
    endtask

    // A low clock enable must ignore a result; the same conversion, repeated, is taken once enabled.
    task automatic t_hold();
        @(posedge clock);
        ce <= 1'b0;
        conv(1'b0, 12'd3200);
        check(chan_value[0], 16'h0000);
        @(posedge clock);
        ce <= 1'b1;
        conv(1'b0, 12'd3200);
        check(chan_value[0], 16'h6c00);
        conv(1'b0, 12'd640);
        $display("test hold done");
    endtask

    initial
    begin
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        t_reset();
        t_scale();
        t_limits();
        t_hold();
        t_flags();
        give_verdict();
    end
endmodule
`default_nettype wire
